// >>> rtl/osd_sync_params.svh
// Purpose: constants for the OSD sync, blanking and output gating block
// Assumes: included by the package and the design module
// Notes:   register index = address on the plain register port
`ifndef OSD_SYNC_PARAMS_SVH
`define OSD_SYNC_PARAMS_SVH

`define ADDR_W         4
`define DATA_W         16
`define REG_IO_CTRL    4'h0
`define REG_BACK_PORCH 4'h1
`define REG_FRONT_PORCH 4'h2
`define REG_CHAN_A     4'h3
`define REG_CHAN_B     4'h4
`define REG_CHAN_C     4'h5
`define REG_STATUS     4'h6

`define IO_POL_BIT     0
`define IO_VVE_BIT     1
`define IO_VHE_BIT     2
`define IO_HE_BIT      3
`define IO_OSC_BIT     4

`define CH_SEL_LSB     0
`define CH_SEL_MSB     2
`define CH_LBG_BIT     3
`define CH_SBG_BIT     4
`define CH_SPR_BIT     5

`define BP_W           6
`define FP_W           9
`define CNT_W          12
`define SEL_RESET      3'h1
`define HB_OFFSET_DOTS 12'h020
`define VB_LINES       6'h14
`define VB_W           6

`endif

// >>> rtl/osd_sync_pkg.sv
// Purpose: types shared by the OSD sync and output gating block
// Assumes: osd_sync_params.svh supplies the sizes
// Notes:   one packed struct holds every flip-flop of the block
`include "osd_sync_params.svh"

package osd_sync_pkg;

  typedef struct packed {
    logic                sync_polarity_sel;
    logic                vsync_edge_sel;
    logic                vsync_sample_hedge_sel;
    logic                horiz_op_edge_sel;
    logic                osc_mode;
    logic [`BP_W-1:0]    back_porch_len;
    logic [`FP_W-1:0]    front_porch_len;
    logic [2:0]          chan_a_char_sel;
    logic [2:0]          chan_b_char_sel;
    logic [2:0]          chan_c_char_sel;
    logic                chan_a_screenbg_en;
    logic                chan_a_sprite_en;
    logic                chan_b_linebg_en;
    logic                chan_b_screenbg_en;
    logic                chan_b_sprite_en;
    logic                chan_c_linebg_en;
    logic                chan_c_screenbg_en;
    logic                chan_c_sprite_en;
    logic                hs_lvl;
    logic                vs_samp;
    logic [`CNT_W-1:0]   dot_cnt;
    logic [`CNT_W-1:0]   line_len;
    logic                vblank;
    logic [`VB_W-1:0]    vb_cnt;
    logic                hblank;
    logic                vsync_det;
    logic                dot_run;
    logic                per_a;
    logic                per_b;
    logic                per_c;
    logic [3:0]          color;
    logic [`DATA_W-1:0]  rdata;
  } osd_state_t;

endpackage : osd_sync_pkg

// >>> rtl/osd_sync_blank_output_ctrl.sv
// Purpose: sync detection, blanking and three-channel output gating
// Assumes: all inputs synchronous to clk (the dot clock)
// Notes:   layer pixels come from the renderer; this block only gates them
`timescale 1ns/1ps
`include "osd_sync_params.svh"

// Summary of operation
// - Polarity bit 0: sync inputs active low; 1: active high.
// - Vertical sync level sampled on chosen hsync edge; detection sets origin.
// - Vertical edge select and sample hsync edge select, all four combinations.
// - Oscillator mode: hsync stops and restarts the dot clock.
// - External clock: operating edge 0 trailing, 1 leading.
// - Vertical blanking generated internally; outputs suppressed throughout.
// - Vertical blanking referenced to the selected vertical sync edge.
// - Horizontal blanking suppresses outputs, referenced to operating edge.
// - Six-bit back porch, 2-dot steps, up to 126 dots.
// - Nine-bit front porch, 2-dot steps, up to 1022 dots.
// - Effective horizontal blanking extended by a fixed positive offset.
// - Character gated off: character dots transparent including lower layers.
// - Line background disabled: line and screen background transparent.
// - Screen background disabled: screen background transparent.
// - Sprite disabled: sprite, trimming and all lower layers transparent.
// - Gating per cell; spilled trimming follows neighbour cell control.
// - Trimming left of first character is never gated.
// - Trimming right of last character follows last character control.
// - Three-bit select gates characters by their two-bit class.
// - Each character has a two-bit output class evaluated per channel.
// - Three display-period outputs and a four-bit colour code.
module osd_sync_blank_output_ctrl
  import osd_sync_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Sync inputs
  input  wire logic                hsync_in,
  input  wire logic                vsync_in,
  // Register port
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [`DATA_W-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [`DATA_W-1:0]  reg_rdata,
  // Layer pixels for the current dot
  input  wire logic                sprite_dot,
  input  wire logic [3:0]          sprite_color,
  input  wire logic                char_dot,
  input  wire logic [3:0]          char_color,
  input  wire logic                trim_left_margin,
  input  wire logic [1:0]          char_output_class,
  input  wire logic                line_bg_dot,
  input  wire logic [3:0]          line_bg_color,
  input  wire logic [3:0]          screen_bg_color,
  // Display outputs
  output logic                     chan_a_period_out,
  output logic                     chan_b_period_out,
  output logic                     chan_c_period_out,
  output logic      [3:0]          color_code_out,
  // Timing status
  output logic                     hblank_out,
  output logic                     vblank_out,
  output logic                     vsync_det_out,
  output logic                     dot_run_out
);

  osd_state_t st_ff;
  osd_state_t nxt_st;

  logic              hs_now;
  logic              vs_now;
  logic              hs_lead;
  logic              hs_trail;
  logic              samp_edge;
  logic              op_edge;
  logic              vdet;
  logic [`CNT_W-1:0] back_dots;
  logic [`CNT_W-1:0] front_dots;
  logic [`CNT_W-1:0] cnt_next;
  logic              ok_a;
  logic              ok_b;
  logic              ok_c;
  logic              blank;

  // Class gate for one channel select
  function automatic logic class_gate(input logic [2:0] sel, input logic [1:0] cls);
    logic g;
    g = 1'b0;
    unique case (sel)
      3'h0: g = 1'b0;
      3'h1: g = 1'b1;
      3'h2: g = cls[0];
      3'h3: g = cls[1];
      3'h4: g = cls[0] | cls[1];
      3'h5: g = ~cls[0];
      3'h6: g = ~cls[1];
      3'h7: g = ~cls[0] | ~cls[1];
    endcase
    return g;
  endfunction : class_gate

  // Topmost present layer decides; a disabled layer hides all below it
  function automatic logic chan_visible(input logic spr_en, input logic chr_ok,
                                        input logic lbg_en, input logic sbg_en);
    logic v;
    v = 1'b0;
    if (sprite_dot) begin
      v = spr_en;
    end else if (char_dot) begin
      v = chr_ok;
    end else if (line_bg_dot) begin
      v = lbg_en;
    end else begin
      v = sbg_en;
    end
    return v;
  endfunction : chan_visible

  always_comb begin
    hs_now     = hsync_in ^ ~st_ff.sync_polarity_sel;
    vs_now     = vsync_in ^ ~st_ff.sync_polarity_sel;
    hs_lead    = hs_now & ~st_ff.hs_lvl;
    hs_trail   = ~hs_now & st_ff.hs_lvl;
    samp_edge  = st_ff.vsync_sample_hedge_sel ? hs_trail : hs_lead;
    op_edge    = st_ff.horiz_op_edge_sel ? hs_lead : hs_trail;
    // Leading edge: newly active at a sample; trailing: newly inactive
    vdet       = samp_edge & (st_ff.vsync_edge_sel ? (~vs_now & st_ff.vs_samp)
                                                   : (vs_now & ~st_ff.vs_samp));
    back_dots  = {{(`CNT_W-`BP_W-1){1'b0}}, st_ff.back_porch_len, 1'b0};
    front_dots = {{(`CNT_W-`FP_W-1){1'b0}}, st_ff.front_porch_len, 1'b0};
    cnt_next   = op_edge ? '0 : st_ff.dot_cnt + 12'h001;
    // Renderer passes the owning cell class for spilled trimming
    ok_a       = trim_left_margin | class_gate(st_ff.chan_a_char_sel, char_output_class);
    ok_b       = trim_left_margin | class_gate(st_ff.chan_b_char_sel, char_output_class);
    ok_c       = trim_left_margin | class_gate(st_ff.chan_c_char_sel, char_output_class);
    blank      = st_ff.hblank | st_ff.vblank;

    nxt_st           = st_ff;
    nxt_st.hs_lvl    = hs_now;
    nxt_st.vsync_det = vdet;
    if (samp_edge) begin
      nxt_st.vs_samp = vs_now;
    end

    // Dot clock runs only outside the hsync pulse in oscillator mode
    nxt_st.dot_run = ~(st_ff.osc_mode & hs_now);

    // Line length learned from the previous line for front porch timing
    nxt_st.dot_cnt = cnt_next;
    if (op_edge) begin
      nxt_st.line_len = st_ff.dot_cnt + 12'h001;
    end

    // Back porch carries a fixed extra offset after the edge
    nxt_st.hblank = hs_now
                  | (cnt_next < back_dots + `HB_OFFSET_DOTS)
                  | (cnt_next + front_dots >= st_ff.line_len);

    if (vdet) begin
      nxt_st.vblank = 1'b1;
      nxt_st.vb_cnt = `VB_LINES;
    end else if (op_edge && st_ff.vblank) begin
      nxt_st.vb_cnt = st_ff.vb_cnt - 6'h01;
      if (st_ff.vb_cnt == 6'h01) begin
        nxt_st.vblank = 1'b0;
      end
    end

    // Channel A has only master screen background and sprite enables
    nxt_st.per_a = ~blank & chan_visible(st_ff.chan_a_sprite_en, ok_a, 1'b1,
                                         st_ff.chan_a_screenbg_en);
    nxt_st.per_b = ~blank & chan_visible(st_ff.chan_a_sprite_en & st_ff.chan_b_sprite_en,
                                         ok_b, st_ff.chan_b_linebg_en,
                                         st_ff.chan_a_screenbg_en
                                         & st_ff.chan_b_screenbg_en);
    nxt_st.per_c = ~blank & chan_visible(st_ff.chan_a_sprite_en & st_ff.chan_c_sprite_en,
                                         ok_c, st_ff.chan_c_linebg_en,
                                         st_ff.chan_a_screenbg_en
                                         & st_ff.chan_c_screenbg_en);

    if (blank) begin
      nxt_st.color = 4'h0;
    end else if (sprite_dot && st_ff.chan_a_sprite_en) begin
      nxt_st.color = sprite_color;
    end else if (char_dot) begin
      nxt_st.color = char_color;
    end else if (line_bg_dot) begin
      nxt_st.color = line_bg_color;
    end else begin
      nxt_st.color = screen_bg_color;
    end

    // Register writes; a write takes one whole command word
    if (reg_wr) begin
      unique case (reg_addr)
        `REG_IO_CTRL: begin
          nxt_st.sync_polarity_sel      = reg_wdata[`IO_POL_BIT];
          nxt_st.vsync_edge_sel         = reg_wdata[`IO_VVE_BIT];
          nxt_st.vsync_sample_hedge_sel = reg_wdata[`IO_VHE_BIT];
          nxt_st.horiz_op_edge_sel      = reg_wdata[`IO_HE_BIT];
          nxt_st.osc_mode               = reg_wdata[`IO_OSC_BIT];
        end
        `REG_BACK_PORCH: begin
          nxt_st.back_porch_len = reg_wdata[`BP_W-1:0];
        end
        `REG_FRONT_PORCH: begin
          nxt_st.front_porch_len = reg_wdata[`FP_W-1:0];
        end
        `REG_CHAN_A: begin
          nxt_st.chan_a_char_sel    = reg_wdata[`CH_SEL_MSB:`CH_SEL_LSB];
          nxt_st.chan_a_screenbg_en = reg_wdata[`CH_SBG_BIT];
          nxt_st.chan_a_sprite_en   = reg_wdata[`CH_SPR_BIT];
        end
        `REG_CHAN_B: begin
          nxt_st.chan_b_char_sel    = reg_wdata[`CH_SEL_MSB:`CH_SEL_LSB];
          nxt_st.chan_b_linebg_en   = reg_wdata[`CH_LBG_BIT];
          nxt_st.chan_b_screenbg_en = reg_wdata[`CH_SBG_BIT];
          nxt_st.chan_b_sprite_en   = reg_wdata[`CH_SPR_BIT];
        end
        `REG_CHAN_C: begin
          nxt_st.chan_c_char_sel    = reg_wdata[`CH_SEL_MSB:`CH_SEL_LSB];
          nxt_st.chan_c_linebg_en   = reg_wdata[`CH_LBG_BIT];
          nxt_st.chan_c_screenbg_en = reg_wdata[`CH_SBG_BIT];
          nxt_st.chan_c_sprite_en   = reg_wdata[`CH_SPR_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_IO_CTRL: begin
          nxt_st.rdata[`IO_POL_BIT] = st_ff.sync_polarity_sel;
          nxt_st.rdata[`IO_VVE_BIT] = st_ff.vsync_edge_sel;
          nxt_st.rdata[`IO_VHE_BIT] = st_ff.vsync_sample_hedge_sel;
          nxt_st.rdata[`IO_HE_BIT]  = st_ff.horiz_op_edge_sel;
          nxt_st.rdata[`IO_OSC_BIT] = st_ff.osc_mode;
        end
        `REG_BACK_PORCH: begin
          nxt_st.rdata[`BP_W-1:0] = st_ff.back_porch_len;
        end
        `REG_FRONT_PORCH: begin
          nxt_st.rdata[`FP_W-1:0] = st_ff.front_porch_len;
        end
        `REG_CHAN_A: begin
          nxt_st.rdata[`CH_SEL_MSB:`CH_SEL_LSB] = st_ff.chan_a_char_sel;
          nxt_st.rdata[`CH_SBG_BIT]             = st_ff.chan_a_screenbg_en;
          nxt_st.rdata[`CH_SPR_BIT]             = st_ff.chan_a_sprite_en;
        end
        `REG_CHAN_B: begin
          nxt_st.rdata[`CH_SEL_MSB:`CH_SEL_LSB] = st_ff.chan_b_char_sel;
          nxt_st.rdata[`CH_LBG_BIT]             = st_ff.chan_b_linebg_en;
          nxt_st.rdata[`CH_SBG_BIT]             = st_ff.chan_b_screenbg_en;
          nxt_st.rdata[`CH_SPR_BIT]             = st_ff.chan_b_sprite_en;
        end
        `REG_CHAN_C: begin
          nxt_st.rdata[`CH_SEL_MSB:`CH_SEL_LSB] = st_ff.chan_c_char_sel;
          nxt_st.rdata[`CH_LBG_BIT]             = st_ff.chan_c_linebg_en;
          nxt_st.rdata[`CH_SBG_BIT]             = st_ff.chan_c_screenbg_en;
          nxt_st.rdata[`CH_SPR_BIT]             = st_ff.chan_c_sprite_en;
        end
        `REG_STATUS: begin
          nxt_st.rdata[0] = st_ff.hblank;
          nxt_st.rdata[1] = st_ff.vblank;
          nxt_st.rdata[2] = st_ff.hs_lvl;
          nxt_st.rdata[3] = st_ff.vs_samp;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff                 <= '0;
      st_ff.chan_a_char_sel <= `SEL_RESET;
      st_ff.chan_b_char_sel <= `SEL_RESET;
      st_ff.chan_c_char_sel <= `SEL_RESET;
      st_ff.hblank          <= 1'b1;
      st_ff.vblank          <= 1'b1;
      st_ff.dot_run         <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata         = st_ff.rdata;
  assign chan_a_period_out = st_ff.per_a;
  assign chan_b_period_out = st_ff.per_b;
  assign chan_c_period_out = st_ff.per_c;
  assign color_code_out    = st_ff.color;
  assign hblank_out        = st_ff.hblank;
  assign vblank_out        = st_ff.vblank;
  assign vsync_det_out     = st_ff.vsync_det;
  assign dot_run_out       = st_ff.dot_run;

  // Checks
  a_blank_kills_out: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.hblank || st_ff.vblank) |=> !chan_a_period_out && !chan_b_period_out
                                       && !chan_c_period_out && color_code_out == 4'h0)
    else $error("output active during blanking");

  a_sync_polarity: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $stable(st_ff.sync_polarity_sel) |-> st_ff.hs_lvl == ($past(hsync_in)
                                         ^ !st_ff.sync_polarity_sel))
    else $error("hsync polarity not applied");

  a_vdet_lead: assert property (@(posedge clk) disable iff (sys_rst)
    samp_edge && !st_ff.vsync_edge_sel && vs_now && !st_ff.vs_samp |=> vsync_det_out)
    else $error("vsync leading edge missed");

  a_vdet_only_edge: assert property (@(posedge clk) disable iff (sys_rst)
    !samp_edge |=> !vsync_det_out)
    else $error("vsync detect off a sample edge");

  a_vblank_start: assert property (@(posedge clk) disable iff (sys_rst)
    vsync_det_out |-> vblank_out ##1 vblank_out)
    else $error("vertical blanking not started");

  a_osc_stop: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.osc_mode && hs_now && !reg_wr |=> !dot_run_out)
    else $error("dot clock not stopped during hsync");

  a_back_porch: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.dot_cnt < back_dots + `HB_OFFSET_DOTS && $stable(st_ff.back_porch_len)
    |-> hblank_out)
    else $error("back porch too short");

  a_front_porch: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.dot_cnt + front_dots >= $past(st_ff.line_len) && $stable(st_ff.line_len)
    && $stable(st_ff.front_porch_len) |-> hblank_out)
    else $error("front porch not blanked");

  a_sel_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.chan_a_char_sel == 3'h0 && char_dot && !sprite_dot && !trim_left_margin
    |=> !chan_a_period_out)
    else $error("channel A shows gated character");

  a_sprite_off_b: assert property (@(posedge clk) disable iff (sys_rst)
    !st_ff.chan_b_sprite_en && sprite_dot |=> !chan_b_period_out)
    else $error("channel B shows disabled sprite");

endmodule : osd_sync_blank_output_ctrl

// >>> dv/osd_sync_src_model.sv
// Purpose: sync source that drives the block's hsync and vsync pins
// Assumes: one dot per clk, continuous lines and frames
// Notes:   vsync changes mid-line so it never coincides with an hsync edge
`timescale 1ns/1ps

module osd_sync_src_model #(
  parameter int LINE    = 128,
  parameter int HS_W    = 8,
  parameter int FRAME   = 24,
  parameter int VS_LINE = 20,
  parameter int VS_LEN  = 3,
  parameter int VS_DOT  = 40
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Polarity of both sync pins
  input  wire logic pol,
  // Sync pins
  output logic      hsync_in,
  output logic      vsync_in
);
  logic [7:0]  dot_ff;
  logic [7:0]  line_ff;
  logic [15:0] pos;
  logic        hs_act;
  logic        vs_act;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dot_ff  <= '0;
      line_ff <= '0;
    end else if (dot_ff == 8'(LINE - 1)) begin
      dot_ff  <= '0;
      line_ff <= (line_ff == 8'(FRAME - 1)) ? 8'h00 : line_ff + 8'h01;
    end else begin
      dot_ff <= dot_ff + 8'h01;
    end
  end

  assign pos      = {line_ff, dot_ff};
  assign hs_act   = dot_ff < 8'(HS_W);
  assign vs_act   = (pos >= 16'(VS_LINE * 256 + VS_DOT)) &&
                    (pos < 16'((VS_LINE + VS_LEN) * 256 + VS_DOT));
  assign hsync_in = pol ? hs_act : ~hs_act;
  assign vsync_in = pol ? vs_act : ~vs_act;
endmodule : osd_sync_src_model

// >>> dv/osd_sync_blank_output_ctrl_bench.sv
// Purpose: self-checking bench for sync, blanking and channel gating
// Assumes: parameter header constants for register map and blanking offset
// Notes:   gating outputs are judged on visible dots, one edge after the blanking flags clear; reset, sync, blanking and oscillator checks are not
`timescale 1ns/1ps
`include "osd_sync_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end

module osd_sync_blank_output_ctrl_bench;
  localparam int LINE  = 128;
  localparam int FRAME = 24;
  logic                clk;
  logic                sys_rst;
  logic                hsync_in;
  logic                vsync_in;
  logic                pol;
  logic [`ADDR_W-1:0]  reg_addr;
  logic [`DATA_W-1:0]  reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [`DATA_W-1:0]  reg_rdata;
  logic                sprite_dot;
  logic                char_dot;
  logic                trim_left_margin;
  logic [1:0]          char_output_class;
  logic                line_bg_dot;
  logic                chan_a_period_out;
  logic                chan_b_period_out;
  logic                chan_c_period_out;
  logic [3:0]          color_code_out;
  logic                hblank_out;
  logic                vblank_out;
  logic                vsync_det_out;
  logic                dot_run_out;
  int                  bad_count;
  int                  num_checks;

  osd_sync_src_model #(.LINE(LINE), .FRAME(FRAME)) src (.clk(clk), .sys_rst(sys_rst),
    .pol(pol), .hsync_in(hsync_in), .vsync_in(vsync_in));

  osd_sync_blank_output_ctrl uut (.clk(clk), .sys_rst(sys_rst), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sprite_dot(sprite_dot), .sprite_color(4'hA),
    .char_dot(char_dot), .char_color(4'h1), .trim_left_margin(trim_left_margin),
    .char_output_class(char_output_class), .line_bg_dot(line_bg_dot), .line_bg_color(4'h3),
    .screen_bg_color(4'h4), .chan_a_period_out(chan_a_period_out),
    .chan_b_period_out(chan_b_period_out), .chan_c_period_out(chan_c_period_out),
    .color_code_out(color_code_out), .hblank_out(hblank_out), .vblank_out(vblank_out),
    .vsync_det_out(vsync_det_out), .dot_run_out(dot_run_out));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd_chk

  // Hold layer inputs, then wait for a dot that is outside both blankings
  task automatic lay(input logic spr, chr, trim, lbg, input logic [1:0] cls);
    int n;
    @(posedge clk);
    sprite_dot        <= spr;
    char_dot          <= chr;
    trim_left_margin  <= trim;
    line_bg_dot       <= lbg;
    char_output_class <= cls;
    @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((hblank_out !== 1'b0 || vblank_out !== 1'b0) && n < 8000);
    // Period outputs lag the blanking flags by one edge
    @(posedge clk);
    #1;
  endtask : lay

  function automatic logic sel_on(input logic [2:0] s, input logic [1:0] c);
    case (s)
      3'h0: return 1'b0;
      3'h1: return 1'b1;
      3'h2: return c[0];
      3'h3: return c[1];
      3'h4: return |c;
      3'h5: return !c[0];
      3'h6: return !c[1];
      default: return !(&c);
    endcase
  endfunction : sel_on

  task automatic t_reset();
    #1;
    `CHK({hblank_out, vblank_out, vsync_det_out, dot_run_out}, 4'hD)
    `CHK({chan_a_period_out, chan_b_period_out, color_code_out}, 6'h00)
    rd_chk(`REG_CHAN_B, 16'h0001);
    rd_chk(4'h7, 16'h0000);
    wr(`REG_BACK_PORCH, 16'hFFFF);
    rd_chk(`REG_BACK_PORCH, 16'h003F);
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 16'h0000)
    wr(`REG_FRONT_PORCH, 16'hFFFF);
    wr(4'h7, 16'hFFFF);
    rd_chk(`REG_FRONT_PORCH, 16'h01FF);
    rd_chk(4'h7, 16'h0000);
  endtask : t_reset

  task automatic t_vsync();
    int  c;
    int  dets;
    int  vbl;
    logic hv;
    logic vv;
    for (int i = 0; i < 4; i++) begin
      vv = i[0];
      hv = i[1];
      pol <= i[0] ^ i[1];
      wr(`REG_IO_CTRL, {11'h000, 1'b0, 1'b1, hv, vv, i[0] ^ i[1]});
      // Polarity flip leaves stale samples behind; let two lines pass
      repeat (2 * LINE) @(posedge clk);
      c = 0;
      do begin
        @(posedge clk);
        #1;
        c++;
      end while (vsync_det_out !== 1'b1 && c < 3 * FRAME * LINE);
      dets = 0;
      vbl  = 0;
      for (c = 1; c <= FRAME * LINE + LINE / 2; c++) begin
        @(posedge clk);
        #1;
        if (vsync_det_out === 1'b1) begin
          dets++;
          `CHK(hsync_in === pol, !hv)
          `CHK(vsync_in === pol, !vv)
          `CHK(vblank_out, 1'b1)
        end
        if (vblank_out === 1'b0 && vbl == 0)
          vbl = c;
      end
      `CHK(dets, 1)
      `CHK(vbl > 19 * LINE && vbl <= 21 * LINE, 1'b1)
    end
  endtask : t_vsync

  task automatic t_hblank(input logic he, input logic [5:0] b, input logic [8:0] f);
    int n;
    wr(`REG_IO_CTRL, {12'h000, he, 3'b000});
    wr(`REG_BACK_PORCH, {10'h000, b});
    wr(`REG_FRONT_PORCH, {7'h00, f});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (!(vblank_out === 1'b0 && hblank_out === 1'b1) && n < 8000);
      while (hblank_out !== 1'b0 && n < 8000) begin
        @(posedge clk);
        #1;
        n++;
      end
      n = 0;
      while (hblank_out === 1'b0 && n < 2000) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    `CHK(n, LINE - 2 * b - 2 * f - `HB_OFFSET_DOTS)
  endtask : t_hblank

  task automatic t_gate_a();
    logic e;
    for (int s = 0; s < 8; s++) begin
      wr(`REG_CHAN_A, {10'h000, 2'b11, 1'b0, s[2:0]});
      for (int c = 0; c < 4; c++) begin
        lay(1'b0, 1'b1, 1'b0, 1'b0, c[1:0]);
        e = sel_on(s[2:0], c[1:0]);
        `CHK(chan_a_period_out, e)
        if (e)
          `CHK(color_code_out, 4'h1)
      end
    end
    // Select off, so only the margin rule can light the channel
    wr(`REG_CHAN_A, 16'h0030);
    lay(1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
    `CHK(chan_a_period_out, 1'b1)
    wr(`REG_CHAN_A, 16'h0031);
    lay(1'b1, 1'b1, 1'b0, 1'b1, 2'b00);
    `CHK(color_code_out, 4'hA)
    lay(1'b0, 1'b0, 1'b0, 1'b1, 2'b00);
    `CHK(color_code_out, 4'h3)
    lay(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
    `CHK(color_code_out, 4'h4)
  endtask : t_gate_a

  function automatic logic po(input int k);
    return (k != 0) ? chan_c_period_out : chan_b_period_out;
  endfunction : po

  task automatic t_gate_bc();
    logic [3:0] a;
    for (int k = 0; k < 2; k++) begin
      a = 4'(`REG_CHAN_B + k);
      wr(a, 16'h0031);
      lay(1'b0, 1'b0, 1'b0, 1'b1, 2'b00);
      `CHK(po(k), 1'b0)
      lay(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b1)
      wr(a, 16'h0039);
      lay(1'b0, 1'b0, 1'b0, 1'b1, 2'b00);
      `CHK(po(k), 1'b1)
      lay(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b1)
      wr(a, 16'h0029);
      lay(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b0)
      wr(a, 16'h0019);
      lay(1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b0)
      lay(1'b0, 1'b1, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b1)
      wr(a, 16'h0038);
      lay(1'b0, 1'b1, 1'b0, 1'b0, 2'b00);
      `CHK(po(k), 1'b0)
    end
  endtask : t_gate_bc

  // Operating edge kept at 0 while the oscillator mode is on
  task automatic t_osc();
    int n;
    wr(`REG_IO_CTRL, 16'h0010);
    // Start from inactive sync so the active wait lands on its first dot
    do begin
      @(posedge clk);
      #1;
    end while (hsync_in !== 1'b1);
    for (int lvl = 0; lvl < 2; lvl++) begin
      n = 0;
      while (hsync_in !== 1'(lvl) && n < 2 * LINE) begin
        @(posedge clk);
        #1;
        n++;
      end
      repeat (2) @(posedge clk);
      #1;
      `CHK(dot_run_out, 1'(lvl))
    end
    wr(`REG_IO_CTRL, 16'h0008);
  endtask : t_osc

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #1_000_000;
    bad_count++;
    end_sim();
  end

  initial begin
    bad_count         = 0;
    num_checks        = 0;
    sys_rst           = 1'b1;
    pol               = 1'b0;
    reg_addr          = '0;
    reg_wdata         = '0;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    sprite_dot        = 1'b0;
    char_dot          = 1'b0;
    trim_left_margin  = 1'b0;
    char_output_class = 2'b00;
    line_bg_dot       = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_vsync();
    t_hblank(1'b1, 6'h04, 9'h008);
    t_hblank(1'b0, 6'h06, 9'h00C);
    t_gate_a();
    t_gate_bc();
    t_osc();
    end_sim();
  end
endmodule : osd_sync_blank_output_ctrl_bench
